// File: core/rse_encoder.sv
// request status encoder with axi4-lite register slave
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RL1) status is 4-bit, bits 31:28 of confirmation word; highest code wins
// (RL2) code 0000 means no status; a null confirmation
// (RL3) 0001 when channel one is preempted by channel zero
// (RL4) 0010 when token cannot be held and last frame of part sent
// (RL5) 0011 on token holding timer expiry, timer enabled, intermediate confirm only
// (RL6) 0101 on own beacon in beacon state or claim won in claim state
// (RL7) 0110 on normal completion with good status
// (RL8) 0111 on frame status mismatch, void/token return, ring change or reset
// (RL9) 1000 when transmit data fifo underruns; frame aborted
// (RL10) 1001 and abort when abort bit cleared or confirmation queue full
// (RL11) 1010 and abort when request class conflicts with ring state
// (RL12) 1011 on mac transmit abort, other beacon, or claim lost
// (RL13) 1100 when rotation timer expires with holding timer disabled
// (RL14) 1101 and abort when the mac resets during the request
// (RL15) 1110 and abort on request or descriptor queue inconsistency
// (RL16) 1111 on internal transmit fault or system bus error
// (RL17) software should reinit queues after 1110, whole device after 1111
// (RL18) after exception codes software may need to retransmit frames
// (RL19) exception code sets confirmation exception flag and channel attention bit
// (RL20) code held in register, cleared at reset and request start, until written
module rse_encoder
	import rse_pkg::*;
#(
	parameter int unsigned ADDR_W = 5
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic transmit_abort_in,
	input wire logic mac_reset_in,
	input wire logic ring_op_in,
	input wire logic tht_expired_in,
	input wire logic trt_expired_in,
	input wire logic my_beacon_in,
	input wire logic other_beacon_in,
	input wire logic claim_won_in,
	input wire logic claim_lost_in,
	input wire logic void_token_in,
	input wire logic frame_status_valid_in,
	input wire logic [7:0] frame_status_in,
	input wire logic preempt_in,
	input wire logic part_done_in,
	input wire logic complete_ok_in,
	input wire logic underrun_in,
	input wire logic cnf_queue_full_in,
	input wire logic desc_error_in,
	input wire logic bus_error_in,
	output logic busy,
	output logic cnf_wr,
	output logic [31:0] cnf_word0,
	output logic [31:0] cnf_word1,
	output logic req_abort
);

	if (ADDR_W < 5) begin : g_bad_addr_w
		$error("rse_encoder: ADDR_W must be at least 5");
	end

	function automatic logic addr_ok(input logic [4:0] a);
		return a inside {OFF_CTRL, OFF_CFG, OFF_EFS, OFF_STAT, OFF_ATTN, OFF_CNF0, OFF_CNF1};
	endfunction : addr_ok

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	rse_regs_s st_ff;
	rse_regs_s nxt_st;
	logic [15:0] ev;
	logic [3:0] enc;
	logic [3:0] base_code;
	logic [31:0] wval;
	logic wr_fire;
	logic wr_start;
	logic conflict;
	logic [3:0] cls;

	rse_prio_enc #(
		.N(16),
		.W(4)
	) u_prio (
		.req(ev),
		.idx(enc)
	);

	assign cls = st_ff.cfg[CFG_CLASS_LSB +: 4];
	assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
	assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
	assign s_axi_arready = !st_ff.rvalid;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign busy = (st_ff.state != ST_IDLE);
	assign cnf_wr = st_ff.cnf_wr;
	assign cnf_word0 = st_ff.cnf0;
	assign cnf_word1 = st_ff.cnf1;
	assign req_abort = st_ff.req_abort;

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st = st_ff;
		nxt_st.cnf_wr = 1'b0;
		nxt_st.req_abort = 1'b0;
		// mac pins cross from the byte clock; frame status must be stable while valid
		nxt_st.s1 = {frame_status_valid_in, void_token_in, claim_lost_in, claim_won_in,
			other_beacon_in, my_beacon_in, trt_expired_in, tht_expired_in,
			ring_op_in, mac_reset_in, transmit_abort_in};
		nxt_st.s2 = st_ff.s1;
		nxt_st.ringop_q = st_ff.s2[MI_RINGOP];
		nxt_st.fs1 = frame_status_in;
		nxt_st.fs2 = st_ff.fs1;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr[4:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		wval = merge(32'h00000000, st_ff.wdata, st_ff.wstrb);
		wr_start = 1'b0;
		if (wr_fire) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = addr_ok(st_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
			case (st_ff.awaddr)
				OFF_CTRL: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.abort_bit = st_ff.wdata[CTRL_ABORT_BIT];
						wr_start = st_ff.wdata[CTRL_START_BIT];
					end
				end
				OFF_CFG: begin
					nxt_st.cfg = 9'(merge({23'h000000, st_ff.cfg}, st_ff.wdata,
						st_ff.wstrb));
				end
				OFF_EFS: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.expected_frame_status = st_ff.wdata[7:0];
					end
				end
				OFF_ATTN: begin
					nxt_st.attn = st_ff.attn & ~wval[1:0];
				end
				default: begin
				end
			endcase
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end

		// read channel
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = addr_ok(s_axi_araddr[4:0]) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr[4:0])
				OFF_CTRL: nxt_st.rdata = {31'h00000000, st_ff.abort_bit};
				OFF_CFG: nxt_st.rdata = {23'h000000, st_ff.cfg};
				OFF_EFS: nxt_st.rdata = {24'h000000, st_ff.expected_frame_status};
				OFF_STAT: nxt_st.rdata = {27'h0000000, busy, st_ff.code};
				OFF_ATTN: nxt_st.rdata = {30'h00000000, st_ff.attn};
				OFF_CNF0: nxt_st.rdata = st_ff.cnf0;
				OFF_CNF1: nxt_st.rdata = st_ff.cnf1;
				default: nxt_st.rdata = 32'h00000000;
			endcase
		end

		// (RL11) class versus ring state
		conflict = (cls >= CLASS_IMM_LO && cls <= CLASS_IMM_HI) ?
			st_ff.s2[MI_RINGOP] : !st_ff.s2[MI_RINGOP];

		// in ST_ACTIVE the code already held competes with new events, so it never falls there
		base_code = (st_ff.state == ST_ACTIVE) ? st_ff.code : CODE_NONE;
		ev = 16'h0000;
		// (RL3) channel one preempted
		ev[CODE_PREEMPTED] = preempt_in && st_ff.cfg[CFG_CHAN_BIT];
		// (RL4) part done
		ev[CODE_PART_DONE] = part_done_in;
		// (RL5) service loss
		ev[CODE_SERVICE_LOSS] = st_ff.s2[MI_THT] && st_ff.cfg[CFG_THT_BIT]
			&& st_ff.cfg[CFG_INTERM_BIT];
		// (RL6) beacon or claim success
		ev[CODE_DONE_BEACON] = (st_ff.cfg[CFG_BEACON_BIT] && st_ff.s2[MI_MYBCN])
			|| (st_ff.cfg[CFG_CLAIM_BIT] && st_ff.s2[MI_CLMWON]);
		// (RL7) normal completion
		ev[CODE_DONE_OK] = complete_ok_in;
		// (RL8) bad confirmation
		ev[CODE_BAD_CNF] = (st_ff.s2[MI_FSVALID] && st_ff.fs2 != st_ff.expected_frame_status)
			|| st_ff.s2[MI_VOIDTK] || st_ff.s2[MI_MACRST]
			|| (st_ff.s2[MI_RINGOP] != st_ff.ringop_q);
		// (RL9) underrun
		ev[CODE_UNDERRUN] = underrun_in;
		// (RL10) host abort
		ev[CODE_HOST_ABORT] = !st_ff.abort_bit || cnf_queue_full_in;
		// (RL12) mac abort
		ev[CODE_MAC_ABORT] = st_ff.s2[MI_TRANSMIT_ABORT_IN]
			|| (st_ff.cfg[CFG_BEACON_BIT] && st_ff.s2[MI_OTHBCN])
			|| (st_ff.cfg[CFG_CLAIM_BIT] && st_ff.s2[MI_CLMLOST]);
		// (RL13) timeout
		ev[CODE_TIMEOUT] = st_ff.s2[MI_TRT] && !st_ff.cfg[CFG_THT_BIT];
		// (RL14) mac reset
		ev[CODE_MAC_RESET] = st_ff.s2[MI_MACRST];
		// (RL15) consistency failure
		ev[CODE_CONSIST] = desc_error_in;
		// (RL16) bus error
		ev[CODE_FATAL] = bus_error_in;
		ev[base_code] = 1'b1;

		case (st_ff.state)
			ST_IDLE: begin
				// (RL20) cleared at start
				if (wr_start) begin
					nxt_st.state = ST_ACTIVE;
					nxt_st.code = conflict ? CODE_BAD_RINGOP : CODE_NONE;
				end
			end
			ST_ACTIVE: begin
				// (RL1) highest code wins
				nxt_st.code = enc;
				// (RL2) null never confirmed
				if (enc >= CODE_DONE_BEACON || (st_ff.cfg[CFG_INTERM_BIT]
					&& enc != CODE_NONE)) begin
					nxt_st.state = ST_CNF;
				end
			end
			ST_CNF: begin
				// (RL1) code into word bits
				nxt_st.cnf_wr = 1'b1;
				nxt_st.cnf0 = 32'h00000000;
				nxt_st.cnf0[CNF0_RS_LSB +: 4] = st_ff.code;
				nxt_st.cnf1 = 32'h00000000;
				// (RL19) exception flags
				if (st_ff.code >= CODE_BAD_CNF) begin
					nxt_st.cnf1[CNF1_EXC_BIT] = 1'b1;
					nxt_st.attn[st_ff.cfg[CFG_CHAN_BIT]] = 1'b1;
				end
				// (RL10) abort on codes 1000 and above, not on 0111
				nxt_st.req_abort = (st_ff.code >= CODE_UNDERRUN);
				// breakpoints keep the request running; events of this cycle carry on
				if (st_ff.code >= CODE_DONE_BEACON) begin
					nxt_st.state = ST_IDLE;
					nxt_st.code = CODE_NONE;
				end else begin
					nxt_st.state = ST_ACTIVE;
					nxt_st.code = enc;
				end
			end
			default: begin
				// (RL16) illegal state
				nxt_st.state = ST_CNF;
				nxt_st.code = CODE_FATAL;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.state <= ST_IDLE;
			st_ff.abort_bit <= ABORT_BIT_RST;
			st_ff.cfg <= CFG_RST;
			st_ff.expected_frame_status <= EFS_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_cnf_code_place: assert property ( // RL1
		st_ff.state == ST_CNF |=> cnf_wr && cnf_word0[31:28] == $past(st_ff.code))
		else $error("confirmation code not placed");
	a_null_no_write: assert property ( // RL2
		cnf_wr |-> cnf_word0[31:28] != CODE_NONE)
		else $error("null code written");
	a_preempt_code: assert property ( // RL3
		st_ff.state == ST_ACTIVE && preempt_in && st_ff.cfg[CFG_CHAN_BIT]
		|=> st_ff.code >= CODE_PREEMPTED)
		else $error("preempt not recorded");
	a_tht_code: assert property ( // RL5
		st_ff.state == ST_ACTIVE && st_ff.s2[MI_THT] && st_ff.cfg[CFG_THT_BIT]
		&& st_ff.cfg[CFG_INTERM_BIT] |=> st_ff.code >= CODE_SERVICE_LOSS)
		else $error("service loss missed");
	a_good_done: assert property ( // RL7
		st_ff.state == ST_ACTIVE && complete_ok_in |=> st_ff.code >= CODE_DONE_OK
		##1 cnf_wr)
		else $error("completion not confirmed");
	a_underrun_code: assert property ( // RL9
		st_ff.state == ST_ACTIVE && underrun_in |=> st_ff.code >= CODE_UNDERRUN)
		else $error("underrun missed");
	a_host_abort: assert property ( // RL10
		st_ff.state == ST_ACTIVE && !st_ff.abort_bit |-> ##2 req_abort)
		else $error("host abort not taken");
	a_ringop_start: assert property ( // RL11
		st_ff.state == ST_IDLE && wr_start && conflict
		|=> st_ff.code == CODE_BAD_RINGOP ##2 req_abort)
		else $error("ring class conflict missed");
	a_mac_abort: assert property ( // RL12
		st_ff.state == ST_ACTIVE && $rose(st_ff.s2[MI_TRANSMIT_ABORT_IN])
		|=> st_ff.code >= CODE_MAC_ABORT)
		else $error("mac abort missed");
	a_timeout_code: assert property ( // RL13
		st_ff.state == ST_ACTIVE && st_ff.s2[MI_TRT] && !st_ff.cfg[CFG_THT_BIT]
		|=> st_ff.code >= CODE_TIMEOUT)
		else $error("timeout missed");
	a_mac_reset: assert property ( // RL14
		st_ff.state == ST_ACTIVE && st_ff.s2[MI_MACRST] |=> st_ff.code >= CODE_MAC_RESET)
		else $error("mac reset missed");
	a_fatal_code: assert property ( // RL16
		st_ff.state == ST_ACTIVE && bus_error_in |=> st_ff.code == CODE_FATAL)
		else $error("bus error not fatal");
	a_exc_flag: assert property ( // RL19
		cnf_wr && cnf_word0[31:28] >= CODE_BAD_CNF |-> cnf_word1[CNF1_EXC_BIT]
		&& st_ff.attn != 2'b00)
		else $error("exception flag missing");
	a_start_clear: assert property ( // RL20
		st_ff.state == ST_IDLE && wr_start && !conflict |=> st_ff.code == CODE_NONE)
		else $error("code not cleared at start");

	c_good_done: cover property (cnf_wr && cnf_word0[31:28] == CODE_DONE_OK);
	c_exception: cover property (cnf_wr && req_abort);
	c_breakpoint: cover property (cnf_wr && cnf_word0[31:28] == CODE_PART_DONE);

endmodule : rse_encoder

// File: core/rse_pkg.sv
// constants, codes, register map and state types of the request status encoder
package rse_pkg;

	// synchronised media-access controller inputs, bit positions in one vector
	localparam int unsigned MAC_W = 11;
	localparam int unsigned MI_TRANSMIT_ABORT_IN = 0;
	localparam int unsigned MI_MACRST = 1;
	localparam int unsigned MI_RINGOP = 2;
	localparam int unsigned MI_THT = 3;
	localparam int unsigned MI_TRT = 4;
	localparam int unsigned MI_MYBCN = 5;
	localparam int unsigned MI_OTHBCN = 6;
	localparam int unsigned MI_CLMWON = 7;
	localparam int unsigned MI_CLMLOST = 8;
	localparam int unsigned MI_VOIDTK = 9;
	localparam int unsigned MI_FSVALID = 10;

	// register byte offsets
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_CFG = 5'h04;
	localparam logic [4:0] OFF_EFS = 5'h08;
	localparam logic [4:0] OFF_STAT = 5'h0C;
	localparam logic [4:0] OFF_ATTN = 5'h10;
	localparam logic [4:0] OFF_CNF0 = 5'h14;
	localparam logic [4:0] OFF_CNF1 = 5'h18;

	// field positions
	localparam int unsigned CTRL_ABORT_BIT = 0;
	localparam int unsigned CTRL_START_BIT = 1;
	localparam int unsigned CFG_CLASS_LSB = 0;
	localparam int unsigned CFG_THT_BIT = 4;
	localparam int unsigned CFG_INTERM_BIT = 5;
	localparam int unsigned CFG_CHAN_BIT = 6;
	localparam int unsigned CFG_BEACON_BIT = 7;
	localparam int unsigned CFG_CLAIM_BIT = 8;
	localparam int unsigned STAT_BUSY_BIT = 4;
	localparam int unsigned CNF0_RS_LSB = 28;
	localparam int unsigned CNF1_EXC_BIT = 13;

	// reset values
	localparam logic ABORT_BIT_RST = 1'b1;
	localparam logic [8:0] CFG_RST = 9'h000;
	localparam logic [7:0] EFS_RST = 8'h00;

	// request status codes
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_PREEMPTED = 4'h1;
	localparam logic [3:0] CODE_PART_DONE = 4'h2;
	localparam logic [3:0] CODE_SERVICE_LOSS = 4'h3;
	localparam logic [3:0] CODE_DONE_BEACON = 4'h5;
	localparam logic [3:0] CODE_DONE_OK = 4'h6;
	localparam logic [3:0] CODE_BAD_CNF = 4'h7;
	localparam logic [3:0] CODE_UNDERRUN = 4'h8;
	localparam logic [3:0] CODE_HOST_ABORT = 4'h9;
	localparam logic [3:0] CODE_BAD_RINGOP = 4'hA;
	localparam logic [3:0] CODE_MAC_ABORT = 4'hB;
	localparam logic [3:0] CODE_TIMEOUT = 4'hC;
	localparam logic [3:0] CODE_MAC_RESET = 4'hD;
	localparam logic [3:0] CODE_CONSIST = 4'hE;
	localparam logic [3:0] CODE_FATAL = 4'hF;

	// immediate request classes
	localparam logic [3:0] CLASS_IMM_LO = 4'h5;
	localparam logic [3:0] CLASS_IMM_HI = 4'h7;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ACTIVE = 3'b010,
		ST_CNF = 3'b100
	} rse_state_e;

	typedef struct packed {
		rse_state_e state;
		logic [3:0] code;
		logic abort_bit;
		logic [8:0] cfg;
		logic [7:0] expected_frame_status;
		logic [1:0] attn;
		logic [31:0] cnf0;
		logic [31:0] cnf1;
		logic cnf_wr;
		logic req_abort;
		logic [MAC_W-1:0] s1;
		logic [MAC_W-1:0] s2;
		logic ringop_q;
		logic [7:0] fs1;
		logic [7:0] fs2;
		logic aw_got;
		logic [4:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rse_regs_s;

endpackage : rse_pkg

// File: core/rse_prio_enc.sv
// priority encoder: index of the highest set request bit
`timescale 1ns/1ps
module rse_prio_enc #(
	parameter int unsigned N = 16,
	parameter int unsigned W = 4
) (
	input wire logic [N-1:0] req,
	output logic [W-1:0] idx
);

	if (N != (1 << W)) begin : g_bad_size
		$error("rse_prio_enc: N must equal 2**W");
	end

	// ascending scan so the last, highest hit wins
	always_comb begin
		idx = '0;
		for (int i = 0; i < N; i++) begin
			if (req[i]) begin
				idx = W'(i);
			end
		end
	end

endmodule : rse_prio_enc

// File: test/rse_mac_model.sv
// mac model: one-cycle status pulses on command, ring level and frame status bus
`timescale 1ns/1ps
module rse_mac_model
	import rse_pkg::*;
(
	input wire logic aclk,
	input wire logic fire,
	input wire logic [3:0] fire_idx,
	input wire logic ring_up,
	input wire logic [7:0] fs_val,
	output logic transmit_abort_in,
	output logic mac_reset_in,
	output logic ring_op_in,
	output logic tht_expired_in,
	output logic trt_expired_in,
	output logic my_beacon_in,
	output logic other_beacon_in,
	output logic claim_won_in,
	output logic claim_lost_in,
	output logic void_token_in,
	output logic frame_status_valid_in,
	output logic [7:0] frame_status_in
);
	logic [MAC_W-1:0] pulse_ff = '0;
	logic [MAC_W-1:0] pins;
	logic [7:0] fs_last_ff = 8'h00;

	always @(posedge aclk) begin
		pulse_ff <= fire ? MAC_W'(1) << fire_idx : '0;
		if (pins[MI_FSVALID])
			fs_last_ff <= fs_val;
	end
	// ring state is a level, so a pulse on its bit inverts it for one cycle
	assign pins = pulse_ff ^ (MAC_W'(ring_up) << MI_RINGOP);
	assign {frame_status_valid_in, void_token_in, claim_lost_in, claim_won_in} = pins[10:7];
	assign {other_beacon_in, my_beacon_in, trt_expired_in, tht_expired_in} = pins[6:3];
	assign {ring_op_in, mac_reset_in, transmit_abort_in} = pins[2:0];
	// a released status bus shows the inverse of its last value, never a stale copy
	assign frame_status_in = pins[MI_FSVALID] ? fs_val : ~fs_last_ff;
endmodule : rse_mac_model

// File: test/test_request_status_encoder.sv
// self-checking bench of the request status encoder against a mac model
`timescale 1ns/1ps
module test_request_status_encoder
	import rse_pkg::*;
;
	typedef struct packed {
		logic [8:0] cfg;
		logic [4:0] ev;
		logic [3:0] code;
	} rse_row_s;
	// events 10h..16h are same-clock inputs, 1Fh is none, the rest a mac pin index
	localparam rse_row_s ROWS [19] = '{
		'{9'h068, 5'h10, CODE_PREEMPTED},
		'{9'h028, 5'h11, CODE_PART_DONE},
		'{9'h038, 5'h03, CODE_SERVICE_LOSS},
		'{9'h088, 5'h05, CODE_DONE_BEACON},
		'{9'h108, 5'h07, CODE_DONE_BEACON},
		'{9'h008, 5'h12, CODE_DONE_OK},
		'{9'h008, 5'h0A, CODE_BAD_CNF},
		'{9'h008, 5'h09, CODE_BAD_CNF},
		'{9'h008, 5'h02, CODE_BAD_CNF},
		'{9'h008, 5'h13, CODE_UNDERRUN},
		'{9'h008, 5'h14, CODE_HOST_ABORT},
		'{9'h005, 5'h1F, CODE_BAD_RINGOP},
		'{9'h008, 5'h00, CODE_MAC_ABORT},
		'{9'h088, 5'h06, CODE_MAC_ABORT},
		'{9'h108, 5'h08, CODE_MAC_ABORT},
		'{9'h008, 5'h04, CODE_TIMEOUT},
		'{9'h008, 5'h01, CODE_MAC_RESET},
		'{9'h048, 5'h15, CODE_CONSIST},
		'{9'h008, 5'h16, CODE_FATAL}
	};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
	logic s_axi_rready = 1'b1, fire = 1'b0, ring_up = 1'b1, ab;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cnf_word0, cnf_word1, w0, w1;
	logic [3:0] s_axi_wstrb = 4'hF, fire_idx = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [6:0] sc = 7'h00;
	logic [7:0] fs_val = 8'h5A, frame_status_in;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic busy, cnf_wr, req_abort, frame_status_valid_in;
	logic transmit_abort_in, mac_reset_in, ring_op_in, tht_expired_in, trt_expired_in;
	logic my_beacon_in, other_beacon_in, claim_won_in, claim_lost_in, void_token_in;
	int fails = 0, cmp_count = 0, cnf_cnt = 0, cyc = 0;

	rse_mac_model mac (.aclk, .fire, .fire_idx, .ring_up, .fs_val, .transmit_abort_in,
		.mac_reset_in, .ring_op_in, .tht_expired_in, .trt_expired_in, .my_beacon_in,
		.other_beacon_in, .claim_won_in, .claim_lost_in, .void_token_in,
		.frame_status_valid_in, .frame_status_in);
	rse_encoder dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .transmit_abort_in, .mac_reset_in,
		.ring_op_in, .tht_expired_in, .trt_expired_in, .my_beacon_in, .other_beacon_in,
		.claim_won_in, .claim_lost_in, .void_token_in, .frame_status_valid_in,
		.frame_status_in, .preempt_in(sc[0]), .part_done_in(sc[1]), .complete_ok_in(sc[2]),
		.underrun_in(sc[3]), .cnf_queue_full_in(sc[4]), .desc_error_in(sc[5]),
		.bus_error_in(sc[6]), .busy, .cnf_wr, .cnf_word0, .cnf_word1, .req_abort);

	initial forever #50 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			report_and_stop();
		end
	end
	// the confirmation pulse lasts one cycle, so it is caught here and not in the tasks
	always @(negedge aclk)
		if (cnf_wr === 1'b1) begin
			w0 = cnf_word0;
			w1 = cnf_word1;
			ab = req_abort;
			cnf_cnt++;
		end
//////////////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// handshakes are judged at the falling edge, where the values of the next rise are settled
	task automatic axi_write(input logic [4:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		logic aw, w, b;
		b = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 40 && !b; n++) begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid === 1'b1;
			if (b)
				check(32'(s_axi_bresp), 32'(er));
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		check(32'(b), 32'h1);
	endtask : axi_write
	task automatic axi_read(input logic [4:0] a, input logic [31:0] ed,
		input logic [1:0] er = RESP_OKAY);
		logic ar, r;
		r = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 40 && !r; n++) begin
			@(negedge aclk);
			ar = s_axi_arvalid & s_axi_arready;
			r = s_axi_rvalid === 1'b1;
			if (r) begin
				check(s_axi_rdata, ed);
				check(32'(s_axi_rresp), 32'(er));
			end
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
		check(32'(r), 32'h1);
	endtask : axi_read
	task automatic start(input logic [8:0] cfg);
		axi_write(OFF_CFG, 32'(cfg));
		axi_write(OFF_CTRL, 32'h3);
	endtask : start
	task automatic raise(input logic [4:0] ev);
		if (ev < 5'h10) begin
			fire_idx <= ev[3:0];
			fire <= 1'b1;
		end else if (ev != 5'h1F)
			sc[ev[2:0]] <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		sc <= 7'h00;
	endtask : raise
	task automatic expect_cnf(input int k, input logic [3:0] c);
		for (int n = 0; n < 40 && cnf_cnt == k; n++)
			@(posedge aclk);
		check(32'(cnf_cnt), 32'(k + 1));
		check(w0, {c, 28'h0});
		check(32'(ab), 32'(c >= CODE_UNDERRUN));
		check(w1, 32'(c >= CODE_BAD_CNF) << CNF1_EXC_BIT);
	endtask : expect_cnf
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : do_reset
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
//////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		int k;
		do_reset();
		foreach (ROWS[i]) begin
			k = cnf_cnt;
			start(ROWS[i].cfg);
			raise(ROWS[i].ev);
			expect_cnf(k, ROWS[i].code);
			if (ROWS[i].code < CODE_DONE_BEACON) begin
				check(32'(busy), 32'h1);
				k = cnf_cnt;
				raise(5'h12);
				expect_cnf(k, CODE_DONE_OK);
			end
			$display("row %0d done", i);
		end
		axi_read(OFF_ATTN, 32'h3);
		axi_write(OFF_ATTN, 32'h3);
		axi_read(OFF_ATTN, 32'h0);
		ring_up <= 1'b0;
		k = cnf_cnt;
		start(9'h008);
		expect_cnf(k, CODE_BAD_RINGOP);
		ring_up <= 1'b1;
		k = cnf_cnt;
		start(9'h008);
		sc <= 7'h2C;
		@(posedge aclk);
		sc <= 7'h00;
		expect_cnf(k, CODE_CONSIST);
		$display("ring and priority test done");
		k = cnf_cnt;
		start(9'h048);
		axi_read(OFF_STAT, 32'h10);
		raise(5'h11);
		repeat (2) @(posedge aclk);
		axi_read(OFF_STAT, 32'h12);
		axi_write(OFF_CTRL, 32'h0);
		expect_cnf(k, CODE_HOST_ABORT);
		k = cnf_cnt;
		start(9'h008);
		raise(5'h12);
		expect_cnf(k, CODE_DONE_OK);
		axi_read(OFF_CNF0, 32'h6000_0000);
		axi_read(OFF_STAT, 32'h0);
		raise(5'h13);
		repeat (4) @(posedge aclk);
		check(32'(cnf_cnt), 32'(k + 1));
		$display("abort and retry test done");
		s_axi_wstrb <= 4'h1;
		axi_write(OFF_CFG, 32'h1FF);
		s_axi_wstrb <= 4'hF;
		axi_read(OFF_CFG, 32'hFF);
		axi_write(5'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
		axi_read(5'h1C, 32'h0, RESP_SLVERR);
		$display("register test done");
		start(9'h008);
		do_reset();
		check(32'(busy), 32'h0);
		for (int i = 0; i < 5; i++)
			axi_read(5'(4 * i), (i == 0) ? 32'h1 : 32'h0);
		$display("reset test done");
		report_and_stop();
	end
endmodule : test_request_status_encoder
